// *** design/current_output_converter_ctrl_map.vh ***
// register offsets, field positions, reset values and codes of the converter control
`ifndef CONVERTER_CTRL_MAP_VH
`define CONVERTER_CTRL_MAP_VH
// byte addresses on the register bus
`define ADDR_CONTROL 4'h0
`define ADDR_DATA_HIGH 4'h4
`define ADDR_DATA_LOW 4'h8
`define ADDR_STATUS 4'hC
// control register fields
`define CTL_ENABLE_BIT 7
`define CTL_SOURCE_MSB 6
`define CTL_SOURCE_LSB 4
`define CTL_SCALE_MSB 1
`define CTL_SCALE_LSB 0
`define CTL_RESET 8'h72
`define CTL_SOURCE_RESET 3'h7
`define CTL_SCALE_RESET 2'h2
`define CTL_WRITE_MASK 8'hF3
// low byte keeps bits 7:6 only
`define LOW_WRITE_MASK 8'hC0
`define DATA_RESET 8'h00
// update source codes
`define SRC_TIMER0 3'h0
`define SRC_TIMER1 3'h1
`define SRC_TIMER2 3'h2
`define SRC_TIMER3 3'h3
`define SRC_RISE 3'h4
`define SRC_FALL 3'h5
`define SRC_ANY 3'h6
`define SRC_HIGH_WRITE 3'h7
// full-scale range codes on the analog side
`define RANGE_HALF_MA 2'h0
`define RANGE_ONE_MA 2'h1
`define RANGE_TWO_MA 2'h2
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** design/strobe_edge_detect.v ***
// synchroniser and edge detector for the external convert strobe
`timescale 1ns/1ps
module strobe_edge_detect
(
  // clock and reset
  input wire clk_sys,
  input wire arst_n,
  // raw pin
  input wire strobeIn,
  // one-cycle edge pulses
  output reg risePulse,
  output reg fallPulse
);
  // ==========================================================
  // two-stage synchroniser plus history
  // ==========================================================
  reg syncFirst; // metastability stage, read only by syncSecond
  reg syncSecond; // settled level
  reg syncPrev; // level one cycle earlier

  // chain and edge pulses
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncFirst <= 1'b0;
      syncSecond <= 1'b0;
      syncPrev <= 1'b0;
      risePulse <= 1'b0;
      fallPulse <= 1'b0;
    end
    else
    begin
      syncFirst <= strobeIn;
      syncSecond <= syncFirst;
      syncPrev <= syncSecond;
      // each edge gives exactly one pulse
      risePulse <= syncSecond & ~syncPrev;
      fallPulse <= ~syncSecond & syncPrev;
    end
  end
endmodule

// *** design/current_dac_update_control.v ***
// register bus slave and update scheduling of the 10-bit current converter
`timescale 1ns/1ps
`include "current_output_converter_ctrl_map.vh"

module current_dac_update_control
(
  // clock and reset
  input wire clk_sys,
  input wire arst_n,
  // axi4-lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // timer overflow pulses, same clock domain
  input wire [3:0] timerOverflow,
  // external convert strobe pin
  input wire externalConvertStrobe,
  // analog side
  output reg [9:0] converterCode,
  output reg [1:0] fullScaleRange,
  output reg converterEnable,
  output reg biasEnable,
  output reg pinAnalogConnect,
  output reg pinDigitalDisable,
  output reg updatePulse
);
  // ==========================================================
  // register state
  // ==========================================================
  // software-visible fields of the control register
  reg converterEnableBit; // control bit 7
  reg [2:0] updateSourceSelect; // control bits 6:4
  reg [1:0] fullScaleSelect; // control bits 1:0
  // data holding registers, copied to the latches on an update
  reg [7:0] dataHighByte; // holding register, word bits 9:2
  reg [7:0] dataLowByte; // holding register, bits 7:6 only
  reg [31:0] updateCount; // number of latch updates

  // write channel capture
  // each half of a write may arrive alone; the half that comes first
  // is parked here so the slave takes address and data in any order
  reg awHeld; // address taken, waiting for data
  reg wHeld; // data taken, waiting for address
  reg [3:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;

  // strobe edges from the synchroniser
  // each is one cycle wide, one per settled level change
  wire risePulse;
  wire fallPulse;

  // ==========================================================
  // helper functions
  // ==========================================================
  // merge a byte lane into an 8-bit register
  // shared by both holding registers so an unselected lane keeps its value
  function [7:0] mergeByte;
    input [7:0] oldVal;
    input [7:0] newVal;
    input lane;
    begin
      mergeByte = lane ? newVal : oldVal;
    end
  endfunction

  // map the scale field onto the analog range code
  // scale 11 also selects the largest range
  function [1:0] decodeRange;
    input [1:0] sel;
    begin
      if (sel[1])
        decodeRange = `RANGE_TWO_MA;
      else if (sel[0])
        decodeRange = `RANGE_ONE_MA;
      else
        decodeRange = `RANGE_HALF_MA;
    end
  endfunction

  // read-back of the control register
  // unused bits 3:2 are forced to zero
  function [7:0] controlValue;
    input en;
    input [2:0] src;
    input [1:0] fs;
    begin
      controlValue = {en, src, 2'b00, fs};
    end
  endfunction

  // ==========================================================
  // strobe synchroniser
  // ==========================================================
  // the pin is asynchronous; two flops settle it before any edge logic
  // reads it, so an update from the pin lands about four cycles late
  strobe_edge_detect edgeDetect
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .strobeIn(externalConvertStrobe),
    .risePulse(risePulse),
    .fallPulse(fallPulse)
  );

  // ==========================================================
  // write decode
  // ==========================================================
  // full write happens when both halves are present
  // a pending response blocks the next write, so only one is in flight
  // unmapped offsets still answer, with an error code and no effect
  wire haveAddr = awHeld | (s_axi_awvalid & s_axi_awready);
  wire haveData = wHeld | (s_axi_wvalid & s_axi_wready);
  wire [3:0] curAddr = awHeld ? awAddr : s_axi_awaddr;
  wire [31:0] curData = wHeld ? wData : s_axi_wdata;
  wire [3:0] curStrb = wHeld ? wStrb : s_axi_wstrb;
  wire doWrite = haveAddr & haveData & ~s_axi_bvalid;
  wire writeControl = doWrite & (curAddr == `ADDR_CONTROL) & curStrb[0];
  wire writeHigh = doWrite & (curAddr == `ADDR_DATA_HIGH) & curStrb[0];
  wire writeLow = doWrite & (curAddr == `ADDR_DATA_LOW) & curStrb[0];
  wire mappedWrite = (curAddr == `ADDR_CONTROL) | (curAddr == `ADDR_DATA_HIGH)
    | (curAddr == `ADDR_DATA_LOW) | (curAddr == `ADDR_STATUS);

  // ==========================================================
  // update event selection
  // ==========================================================
  // exactly one event source is live at a time; timer pulses are already
  // on this clock and need no synchroniser
  reg updateEvent;
  always @*
  begin
    case (updateSourceSelect)
      `SRC_TIMER0: updateEvent = timerOverflow[0];
      `SRC_TIMER1: updateEvent = timerOverflow[1];
      `SRC_TIMER2: updateEvent = timerOverflow[2];
      `SRC_TIMER3: updateEvent = timerOverflow[3];
      `SRC_RISE: updateEvent = risePulse;
      `SRC_FALL: updateEvent = fallPulse;
      `SRC_ANY: updateEvent = risePulse | fallPulse;
      `SRC_HIGH_WRITE: updateEvent = writeHigh;
      default: updateEvent = 1'b0;
    endcase
  end

  // new high byte used when the update is caused by its own write
  // a low write in the update cycle is included, so no byte is lost
  wire [7:0] next_high = mergeByte(dataHighByte, curData[7:0], writeHigh);
  wire [7:0] next_low = mergeByte(dataLowByte, curData[7:0] & `LOW_WRITE_MASK, writeLow);

  // ==========================================================
  // write channel and register updates
  // ==========================================================
  // a half that arrives alone is parked until the other comes, then one write is performed
  // and answered; both channels stay closed until the answer is taken
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 4'h0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      converterEnableBit <= 1'b0;
      // control fields reset to write-triggered updates at full scale
      updateSourceSelect <= `CTL_SOURCE_RESET;
      fullScaleSelect <= `CTL_SCALE_RESET;
      dataHighByte <= `DATA_RESET;
      dataLowByte <= `DATA_RESET;
    end
    else
    begin
      // address capture
      if (s_axi_awvalid & s_axi_awready & ~doWrite)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      // data capture
      if (s_axi_wvalid & s_axi_wready & ~doWrite)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // both halves present: perform write and answer
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mappedWrite ? `RESP_OKAY : `RESP_SLVERR;
      end
      // response taken: reopen both channels
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // control register
      // bits 3:2 are not stored and read back as zero
      if (writeControl)
      begin
        converterEnableBit <= curData[`CTL_ENABLE_BIT];
        updateSourceSelect <= curData[`CTL_SOURCE_MSB:`CTL_SOURCE_LSB];
        fullScaleSelect <= curData[`CTL_SCALE_MSB:`CTL_SCALE_LSB];
      end
      // holding registers never touch the output directly
      // they load on every write, whatever the update source
      dataHighByte <= next_high;
      dataLowByte <= next_low;
    end
  end

  // ==========================================================
  // converter input latches and analog controls
  // ==========================================================
  // the code only moves on an update event, and both bytes land on
  // the same edge so the analog side never sees a half-old word
  // the enable fans out to bias, pin and converter in one flop stage
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // outputs reset to a disabled converter at the largest range
      converterCode <= 10'h000;
      fullScaleRange <= `RANGE_TWO_MA;
      converterEnable <= 1'b0;
      biasEnable <= 1'b0;
      pinAnalogConnect <= 1'b0;
      pinDigitalDisable <= 1'b0;
      updatePulse <= 1'b0;
      updateCount <= 32'h0000_0000;
    end
    else
    begin
      updatePulse <= updateEvent;
      // both bytes copied at once, left justified
      if (updateEvent)
      begin
        converterCode <= {next_high, next_low[7:6]};
        updateCount <= updateCount + 32'h0000_0001;
      end
      fullScaleRange <= decodeRange(fullScaleSelect);
      converterEnable <= converterEnableBit;
      biasEnable <= converterEnableBit;
      // pin is plain gpio while disabled, analog while enabled
      pinAnalogConnect <= converterEnableBit;
      pinDigitalDisable <= converterEnableBit;
    end
  end

  // ==========================================================
  // read channel
  // ==========================================================
  // one read at a time: arready drops while data waits for rready
  // status reads are live and have no side effects
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_CONTROL:
            s_axi_rdata <= {24'h00_0000,
              controlValue(converterEnableBit, updateSourceSelect, fullScaleSelect)};
          `ADDR_DATA_HIGH: s_axi_rdata <= {24'h00_0000, dataHighByte};
          `ADDR_DATA_LOW: s_axi_rdata <= {24'h00_0000, dataLowByte};
          // status: live code in 9:0, update count in 31:16
          `ADDR_STATUS: s_axi_rdata <= {updateCount[15:0], 6'h00, converterCode};
          // unmapped read: zero data with an error
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
        // answer taken: reopen the address channel
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// *** tb/axi_lite_cpu.sv ***
// processor core model: axi4-lite master issuing single register accesses
`timescale 1ns/1ps
module axi_lite_cpu
(
  // clock
  input wire clk_sys,
  // write channels
  output reg [3:0] s_axi_awaddr = 4'h0,
  output reg s_axi_awvalid = 1'b0,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata = 32'h0000_0000,
  output reg [3:0] s_axi_wstrb = 4'h0,
  output reg s_axi_wvalid = 1'b0,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready = 1'b0,
  // read channels
  output reg [3:0] s_axi_araddr = 4'h0,
  output reg s_axi_arvalid = 1'b0,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready = 1'b0
);
  // =====================================
  // one write: address and data offered together, each released when taken
  task wr(input [3:0] a, input [7:0] d, output [1:0] r);
  begin
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  end
  endtask

  // one read: request held until taken, data taken with rvalid
  task rd(input [3:0] a, output [31:0] d, output [1:0] r);
  begin
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  end
  endtask
endmodule

// *** tb/dac_update_chk.sv ***
// checker of bus handshakes and converter outputs at the block's ports
`timescale 1ns/1ps
module dac_update_chk
(
  // clock and reset
  input wire clk_sys, input wire arst_n,
  // bus
  input wire [3:0] s_axi_awaddr, input wire s_axi_awvalid, input wire s_axi_awready,
  input wire [31:0] s_axi_wdata, input wire [3:0] s_axi_wstrb, input wire s_axi_wvalid,
  input wire s_axi_wready, input wire [1:0] s_axi_bresp, input wire s_axi_bvalid,
  input wire s_axi_bready, input wire s_axi_arvalid, input wire s_axi_arready,
  input wire [31:0] s_axi_rdata, input wire s_axi_rvalid, input wire s_axi_rready,
  // analog side
  input wire [9:0] converterCode, input wire [1:0] fullScaleRange,
  input wire converterEnable, input wire biasEnable, input wire pinAnalogConnect,
  input wire pinDigitalDisable, input wire updatePulse
);
  // =====================================
  // control write taken in one cycle, and its expected fields
  wire ctlWr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready
    & (s_axi_awaddr == 4'h0) & s_axi_wstrb[0];
  wire enBit = s_axi_wdata[7];
  wire [1:0] scaleExp = s_axi_wdata[1] ? 2'h2 : {1'b0, s_axi_wdata[0]};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wrResp;
    s_axi_bvalid && !s_axi_awready;
  endsequence
  property p_wresp; s_wrTaken |=> s_wrResp; endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_enable; ctlWr |=> ##1 converterEnable == $past(enBit, 2); endproperty
  property p_scale; ctlWr |=> ##1 fullScaleRange == $past(scaleExp, 2); endproperty
  property p_bias; biasEnable == converterEnable; endproperty
  property p_pin; pinAnalogConnect == converterEnable && pinDigitalDisable == converterEnable;
  endproperty
  property p_latch; $changed(converterCode) |-> updatePulse; endproperty
  a_wresp: assert property (p_wresp) else $error("no write response");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rans: assert property (p_rans) else $error("no read answer");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_enable: assert property (p_enable) else $error("enable wrong");
  a_scale: assert property (p_scale) else $error("scale wrong");
  a_bias: assert property (p_bias) else $error("bias differs");
  a_pin: assert property (p_pin) else $error("pin control differs");
  a_latch: assert property (p_latch) else $error("code moved without update");
endmodule
bind current_dac_update_control dac_update_chk chk (.*);

// *** tb/tb.sv ***
// self-checking bench of the converter update control
`timescale 1ns/1ps
module tb;
  // =====================================
  // stimulus and wires
  reg clk_sys = 1'b0;
  reg arst_n = 1'b0;
  reg [3:0] timerOverflow = 4'h0;
  reg externalConvertStrobe = 1'b0;
  wire [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [1:0] s_axi_bresp, s_axi_rresp, fullScaleRange;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire [9:0] converterCode;
  wire converterEnable, biasEnable, pinAnalogConnect, pinDigitalDisable, updatePulse;
  // model state: integers for data bytes, code and update count
  integer n_fail = 0, comparisons = 0, seed = 15262, cycles = 0;
  integer hi = 0, lo = 0, expCode = 0, nUpd = 0, seenUpd = 0, m;
  reg [7:0] ctl = 8'h72;
  reg [31:0] r;
  reg [1:0] resp;
  reg [7:0] port0CrossbarSkip = 8'h00; // crossbar skip, kept by software

  current_dac_update_control DUT (.*);
  axi_lite_cpu cpu (.*);

  initial forever #5 clk_sys = ~clk_sys;

  // count update pulses and cut hangs short
  always @(posedge clk_sys)
  begin
    if (updatePulse === 1'b1) seenUpd = seenUpd + 1;
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      n_fail = n_fail + 1;
      stop_test;
    end
  end

  // =====================================
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask

  // model latch event, then compare code and pulse count
  task upd;
  begin
    expCode = hi * 4 + lo / 64;
    nUpd = nUpd + 1;
  end
  endtask
  task settle(input integer n);
  begin
    repeat (n) @(posedge clk_sys);
    chk(converterCode, expCode);
    chk(seenUpd, nUpd);
  end
  endtask

  // register write with model update
  task wr(input [3:0] a, input [7:0] d);
  begin
    cpu.wr(a, d, resp);
    chk(resp, 2'h0);
    if (a == 4'h0) ctl = d;
    if (a == 4'h8) lo = d & 8'hC0;
    if (a == 4'h4) hi = d;
    if (a == 4'h4 && ctl[6:4] == 3'h7) upd;
    settle(2);
  end
  endtask
  task load;
  begin
    r = $random(seed);
    wr(4'h8, r[7:0]);
    wr(4'h4, r[15:8]);
  end
  endtask
  task tick(input [3:0] v);
  begin
    timerOverflow <= v;
    @(posedge clk_sys);
    timerOverflow <= 4'h0;
    if (v[ctl[5:4]]) upd;
    settle(3);
  end
  endtask
  task pin(input v);
  begin
    externalConvertStrobe <= v;
    if ((v && ctl[6:4] != 3'h5) || (!v && ctl[6:4] != 3'h4)) upd;
    settle(8);
  end
  endtask

  task stop_test;
  begin
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // =====================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    chk(fullScaleRange, 2'h2);
    chk(pinDigitalDisable, 1'b0);
    cpu.rd(4'h0, r, resp);
    chk(r, 32'h0000_0072);
    chk(resp, 2'h0);
    // software skips the converter pin before enabling it
    port0CrossbarSkip[1] = 1'b1;
    // enable and each scale code
    for (m = 0; m < 4; m = m + 1)
    begin
      wr(4'h0, {m[0], 3'h7, 2'h0, m[1:0]});
      chk(fullScaleRange, m[1] ? 2'h2 : m[1:0]);
      chk(converterEnable, m[0]);
      chk(biasEnable, m[0]);
      chk(pinAnalogConnect, m[0]);
      chk(pinDigitalDisable, m[0]);
    end
    // high byte write updates, low byte held
    repeat (5) load;
    wr(4'h8, 8'h00);
    wr(4'h4, 8'h5A);
    // unmapped offset: error answer, output untouched
    cpu.wr(4'h2, 8'hFF, resp);
    chk(resp, 2'h2);
    settle(2);
    cpu.rd(4'h2, r, resp);
    chk(resp, 2'h2);
    chk(r, 32'h0000_0000);
    // timer overflow sources: foreign timers ignored
    for (m = 0; m < 4; m = m + 1)
    begin
      wr(4'h0, {1'b1, m[2:0], 4'h2});
      load;
      tick(~(4'h1 << m));
      tick(4'h1 << m);
    end
    // strobe edge sources
    for (m = 4; m < 7; m = m + 1)
    begin
      wr(4'h0, {1'b1, m[2:0], 4'h2});
      load;
      pin(1'b1);
      pin(1'b0);
    end
    cpu.rd(4'hC, r, resp);
    chk(r[9:0], expCode);
    chk(r[31:16], nUpd);
    chk(resp, 2'h0);
    cpu.rd(4'h8, r, resp);
    chk(r, lo);
    stop_test;
  end
endmodule
